// ### src/vsr_consts.svh
`ifndef VSR_CONSTS_SVH
`define VSR_CONSTS_SVH

// word and field layout of one serial frame
`define VSR_WORD_W 16
`define VSR_RW_BIT 15
`define VSR_ADDR_HI 14
`define VSR_ADDR_LO 8
`define VSR_DATA_HI 7
`define VSR_BIT_LAST 4'hF

// register byte addresses, lower byte of each word
`define VSR_ADDR_ALM_Z 7'h70
`define VSR_ADDR_SEL 7'h72
`define VSR_ADDR_X 7'h74
`define VSR_ADDR_Y 7'h76
`define VSR_ADDR_Z 7'h78
`define VSR_ADDR_EVEN 7'h7E

// reset values and field widths
`define VSR_RESET_WORD 16'h0000
`define VSR_RESET_SEL 8'h00
`define VSR_RESET_BIN 12'h000
`define VSR_BIN_W 12
`define VSR_BIN_PAD 4'h0
`define VSR_SEL_PAD 8'h00

// selector codes
`define VSR_CODE_LAST 3'h6
`define VSR_FIXED_FIRST 3'h4
`define VSR_EXAMPLE_WORD 16'hF202
`define VSR_EXAMPLE_CODE 8'h02

// array sizes
`define VSR_AXES 3
`define VSR_METRICS 7

`endif

// ### src/vsr_link_if.sv
`timescale 1ns/1ns
// carries decoded frames to the registers and read data back
interface vsr_link_if;
   logic cmd_vld;
   vsr_pkg::vsr_word_t cmd_word;
   vsr_pkg::vsr_word_t rd_word;
   modport port (output cmd_vld, output cmd_word, input rd_word);
   modport regs (input cmd_vld, input cmd_word, output rd_word);
endinterface

// ### src/vsr_pkg.sv
package vsr_pkg;
   typedef logic [15:0] vsr_word_t;
   typedef logic [11:0] vsr_bin_t;
   // statistic chosen by the selector's low three bits
   typedef enum logic [2:0] {
      VSR_MEAN = 3'b000,
      VSR_STD_DEV = 3'b001,
      VSR_PEAK = 3'b010,
      VSR_PEAK_TO_PEAK = 3'b011,
      VSR_CREST = 3'b100,
      VSR_KURTOSIS = 3'b101,
      VSR_SKEWNESS = 3'b110
   } vsr_metric_t;
endpackage

// ### src/vsr_readout.sv
`timescale 1ns/1ns
`include "vsr_consts.svh"
// Summary of operation
// - alarm bin in low twelve bits
// - bin and peak amplitude load together
// - selector picks statistic for all axes
// - codes 000..110 mean through skewness
// - codes 0..3 use buffer sample format
// - fixed metrics integer part in 15:8
// - fixed metrics fraction in 7:0
// - x result read-only, selected statistic
// - y result read-only, selected statistic
// - z result read-only, selected statistic
module vsr_readout (
   // clock and reset
   input logic mclk,
   input logic resetn,
   // serial pins
   input logic sclk,
   input logic cs_n,
   input logic mosi,
   output logic miso,
   // statistic engine, per axis and per metric, preformatted
   input vsr_pkg::vsr_word_t stat_in [`VSR_AXES][`VSR_METRICS],
   output logic [2:0] stat_code,
   output logic stat_fixed_fmt,
   // z peak alarm capture
   input logic alm_load,
   input vsr_pkg::vsr_bin_t alm_bin_in,
   input vsr_pkg::vsr_word_t alm_peak_in,
   output vsr_pkg::vsr_word_t peak_alarm_value
);
   import vsr_pkg::*;

   vsr_link_if link ();

   logic [7:0] sel_r;
   vsr_word_t res_r [`VSR_AXES];
   vsr_word_t pick [`VSR_AXES];
   vsr_word_t rd_word_r;
   vsr_bin_t bin_r;
   vsr_word_t peak_r;
   logic fixed_r;
   logic is_wr;
   logic sel_wr;
   logic rd_cmd;
   logic [6:0] addr_raw;
   logic [6:0] addr;
   vsr_metric_t code;

   vsr_spi_port u_port (
      .mclk(mclk),
      .resetn(resetn),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .miso(miso),
      .lnk(link.port)
   );

   // frame decode; odd read addresses fold onto their word
   assign is_wr = link.cmd_word[`VSR_RW_BIT];
   assign addr_raw = link.cmd_word[`VSR_ADDR_HI:`VSR_ADDR_LO];
   assign addr = addr_raw & `VSR_ADDR_EVEN;
   assign rd_cmd = link.cmd_vld & ~is_wr;
   // a write to the upper byte never reaches the selector
   // only the lower byte address steers the selector
   assign sel_wr = link.cmd_vld & is_wr & (addr_raw == `VSR_ADDR_SEL);
   assign code = vsr_metric_t'(sel_r[2:0]);

   // selector byte, upper bits stored but ignored
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sel_r <= `VSR_RESET_SEL;
      end else if (sel_wr) begin
         sel_r <= link.cmd_word[`VSR_DATA_HI:0];
      end
   end

   // one selector drives every axis; code 111 reads zero
   generate
      for (genvar a = 0; a < `VSR_AXES; a++) begin : g_axis
         always_comb begin
            pick[a] = `VSR_RESET_WORD;
            if (code <= `VSR_CODE_LAST) begin
               pick[a] = stat_in[a][code];
            end
         end
         // live values: a read sees the engine's output registered one cycle earlier
         // result registers reset to zero, refreshed every cycle
         // two cycles after a selector write the new pick lands
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               res_r[a] <= `VSR_RESET_WORD;
            end else begin
               res_r[a] <= pick[a];
            end
         end
      end
   endgenerate

   // codes below crest factor keep the buffer format
   // the engine hands fixed metrics as 8.8, passed unchanged
   // flag tells the engine which format to produce
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fixed_r <= 1'b0;
      end else begin
         fixed_r <= (code >= `VSR_FIXED_FIRST) &&
                    (code <= `VSR_CODE_LAST);
      end
   end

   // bin and amplitude share one strobe, never torn apart
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bin_r <= `VSR_RESET_BIN;
         peak_r <= `VSR_RESET_WORD;
      end else if (alm_load) begin
         bin_r <= alm_bin_in;
         peak_r <= alm_peak_in;
      end
   end

   // read data is shifted out in the following frame
   // upper four bits of the bin word read as zero
   // z result read-only at 78
   // odd addresses were folded by the decode; others answer zero
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_word_r <= `VSR_RESET_WORD;
      end else if (rd_cmd) begin
         case (addr)
            `VSR_ADDR_ALM_Z: rd_word_r <= {`VSR_BIN_PAD, bin_r};
            `VSR_ADDR_SEL: rd_word_r <= {`VSR_SEL_PAD, sel_r};
            `VSR_ADDR_X: rd_word_r <= res_r[0];
            `VSR_ADDR_Y: rd_word_r <= res_r[1];
            `VSR_ADDR_Z: rd_word_r <= res_r[2];
            default: rd_word_r <= `VSR_RESET_WORD;
         endcase
      end
   end

   assign link.rd_word = rd_word_r;
   assign stat_code = code;
   assign stat_fixed_fmt = fixed_r;
   assign peak_alarm_value = peak_r;

   default clocking rd_cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // steps of a selector write and of a register read
   sequence sel_write_s;
      sel_wr;
   endsequence
   sequence sel_defined_s;
      sel_wr && link.cmd_word[2:0] <= `VSR_CODE_LAST;
   endsequence
   sequence read_of_s(logic [6:0] where);
      rd_cmd && addr == where;
   endsequence

   bin_upper_zero_a: assert property (
      read_of_s(`VSR_ADDR_ALM_Z) |=>
         rd_word_r[15:12] == `VSR_BIN_PAD && rd_word_r[11:0] == $past(bin_r))
      else $error("alarm bin word wrong");
   alarm_pair_a: assert property (
      alm_load |=> bin_r == $past(alm_bin_in) && peak_r == $past(alm_peak_in))
      else $error("bin and peak not loaded together");
   example_write_a: assert property (
      link.cmd_vld && link.cmd_word == `VSR_EXAMPLE_WORD |=>
         sel_r == `VSR_EXAMPLE_CODE)
      else $error("selector example write lost");
   format_flag_a: assert property (
      sel_write_s ##2 1'b1 |->
         fixed_r == ($past(link.cmd_word[2:0], 2) >= `VSR_FIXED_FIRST &&
                     $past(link.cmd_word[2:0], 2) <= `VSR_CODE_LAST))
      else $error("format flag not following selector");
   axes_follow_a: assert property (
      sel_defined_s ##2 1'b1 |->
         res_r[0] == $past(stat_in[0][link.cmd_word[2:0]]) &&
         res_r[1] == $past(stat_in[1][link.cmd_word[2:0]]) &&
         res_r[2] == $past(stat_in[2][link.cmd_word[2:0]]))
      else $error("results not refreshed after selector write");
   bad_code_zero_a: assert property (
      sel_r[2:0] > `VSR_CODE_LAST |=> res_r[0] == `VSR_RESET_WORD)
      else $error("undefined code gave data");
   x_read_a: assert property (
      read_of_s(`VSR_ADDR_X) |=> rd_word_r == $past(res_r[0]))
      else $error("x result read wrong");
   z_read_a: assert property (
      read_of_s(`VSR_ADDR_Z) |=> rd_word_r == $past(res_r[2]))
      else $error("z result read wrong");

   // reads of the remaining words and the held registers
   y_read_a: assert property (
      read_of_s(`VSR_ADDR_Y) |=> rd_word_r == $past(res_r[1]))
      else $error("y result read wrong");
   sel_read_a: assert property (
      read_of_s(`VSR_ADDR_SEL) |=>
         rd_word_r == {`VSR_SEL_PAD, $past(sel_r)})
      else $error("selector read wrong");
   // only a selector write may move the selector
   sel_hold_a: assert property (
      !sel_wr |=> $stable(sel_r))
      else $error("selector moved without a write");
   // bin and amplitude move only on the capture strobe
   alarm_hold_a: assert property (
      !alm_load |=> $stable(bin_r) && $stable(peak_r))
      else $error("alarm pair moved without a strobe");
   // the unused code never claims the fixed-point format
   bad_code_fmt_a: assert property (
      code > `VSR_CODE_LAST |=> !fixed_r)
      else $error("format flag set for undefined code");
   // a write frame never disturbs the pending read answer
   write_no_answer_a: assert property (
      link.cmd_vld && is_wr |=> $stable(rd_word_r))
      else $error("write frame changed read data");
endmodule

// ### src/vsr_spi_port.sv
`timescale 1ns/1ns
`include "vsr_consts.svh"
module vsr_spi_port (
   // clock and reset
   input logic mclk,
   input logic resetn,
   // serial pins
   input logic sclk,
   input logic cs_n,
   input logic mosi,
   output logic miso,
   // register side
   vsr_link_if.port lnk
);
   import vsr_pkg::*;

   logic [2:0] sclk_s_r;
   logic [2:0] cs_s_r;
   logic [1:0] mosi_s_r;
   logic [3:0] cnt_r;
   logic [14:0] rx_r;
   vsr_word_t cmd_word_r;
   vsr_word_t tx_r;
   logic cmd_vld_r;
   logic tx_out_r;
   logic active;
   logic rise;
   logic fall;
   logic cs_fall;

   // two flops per pin; bit [2] only keeps history for edges
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sclk_s_r <= '1;
         cs_s_r <= '1;
         mosi_s_r <= '0;
      end else begin
         sclk_s_r <= {sclk_s_r[1:0], sclk};
         cs_s_r <= {cs_s_r[1:0], cs_n};
         mosi_s_r <= {mosi_s_r[0], mosi};
      end
   end

   // edges seen after the second flop only
   assign active = ~cs_s_r[1];
   assign rise = sclk_s_r[1] & ~sclk_s_r[2];
   assign fall = ~sclk_s_r[1] & sclk_s_r[2];
   assign cs_fall = ~cs_s_r[1] & cs_s_r[2];

   // shift in on rising sclk, msb first; select high restarts count
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
         rx_r <= '0;
      end else if (!active) begin
         cnt_r <= '0;
      end else if (rise) begin
         cnt_r <= cnt_r + 4'h1;
         rx_r <= {rx_r[13:0], mosi_s_r[1]};
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cmd_vld_r <= 1'b0;
         cmd_word_r <= `VSR_RESET_WORD;
      end else begin
         cmd_vld_r <= active & rise & (cnt_r == `VSR_BIT_LAST);
         if (active & rise & (cnt_r == `VSR_BIT_LAST)) begin
            cmd_word_r <= {rx_r, mosi_s_r[1]};
         end
      end
   end

   // answer to the previous frame's read, shifted on falling sclk
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_r <= `VSR_RESET_WORD;
         tx_out_r <= 1'b0;
      end else if (cs_fall) begin
         tx_r <= lnk.rd_word;
      end else if (active & fall) begin
         tx_out_r <= tx_r[`VSR_WORD_W-1];
         tx_r <= {tx_r[14:0], 1'b0};
      end
   end

   assign miso = tx_out_r;
   assign lnk.cmd_vld = cmd_vld_r;
   assign lnk.cmd_word = cmd_word_r;

   default clocking spi_cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   frame_length_a: assert property (
      cmd_vld_r |-> $past(cnt_r) == `VSR_BIT_LAST && $past(rise))
      else $error("word ended before sixteen bits");
   idle_quiet_a: assert property (
      cs_s_r[1] && cs_s_r[2] |=> !cmd_vld_r)
      else $error("word taken while deselected");
endmodule

// ### tb/vsr_host_model.sv
`timescale 1ns/1ns
module vsr_host_model (
   // clock
   input wire logic mclk,
   // serial pins
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   import vsr_pkg::*;
   // phase length, kept above the 4-cycle minimum
   localparam int HALF = 6;
   // idle: deselected, clock parked high
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic xfer(input vsr_word_t tx, output vsr_word_t rx);
      @(posedge mclk);
      cs_n <= 1'b0;
      wait_clk(HALF);
      for (int i = 15; i >= 0; i--) begin
         sclk <= 1'b0;
         mosi <= tx[i];
         wait_clk(HALF);
         // miso settled for several cycles before this rise
         sclk <= 1'b1;
         rx[i] = miso;
         wait_clk(HALF);
      end
      cs_n <= 1'b1;
      // released line flips so a stale bit is never mistaken
      mosi <= ~mosi;
      wait_clk(8);
   endtask
endmodule

// ### tb/vsr_readout_bench.sv
`timescale 1ns/1ns
`include "vsr_consts.svh"
module vsr_readout_bench;
   import vsr_pkg::*;
   logic mclk, resetn, sclk, cs_n, mosi, miso, alm_load, stat_fixed_fmt;
   logic [2:0] stat_code;
   vsr_word_t stat_in [`VSR_AXES][`VSR_METRICS];
   vsr_bin_t alm_bin_in;
   vsr_word_t alm_peak_in, peak_alarm_value, rd, exp_word;
   logic fixed_exp;
   int fails, samples_checked;
   // last two codes: don't-care bits set, then the unused code
   logic [7:0] codes [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
      8'h06, 8'h0D, 8'h07};
   logic [6:0] addrs [6] = '{7'h70, 7'h72, 7'h74, 7'h76, 7'h78, 7'h7A};

   vsr_readout vsr_readout_inst (.mclk, .resetn, .sclk, .cs_n, .mosi,
      .miso, .stat_in, .stat_code, .stat_fixed_fmt, .alm_load,
      .alm_bin_in, .alm_peak_in, .peak_alarm_value);
   vsr_host_model vsr_host_model_inst (.mclk, .sclk, .cs_n, .mosi, .miso);

   // 125 MHz
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   function automatic vsr_word_t stat_val(int a, int m);
      return {4'(a + 1), 4'(m), 8'hA5};
   endfunction
   task automatic check(input vsr_word_t got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h want %h", $time, what,
            got, exp);
      end
   endtask
   task automatic reg_write(input logic [6:0] addr, input logic [7:0] d);
      vsr_word_t unused;
      vsr_host_model_inst.xfer({1'b1, addr, d}, unused);
   endtask
   // answer arrives in the frame after the command
   task automatic reg_read(input logic [6:0] addr, output vsr_word_t d);
      vsr_host_model_inst.xfer({1'b0, addr, 8'h00}, d);
      vsr_host_model_inst.xfer(16'h0000, d);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // watchdog: about 110 frames of 210 cycles, nearly doubled
   initial begin
      repeat (40000) @(posedge mclk);
      fails++;
      $display("unexpected at %0t: run hung", $time);
      wrap_up();
   end

   initial begin
      resetn = 1'b0;
      alm_load = 1'b0;
      alm_bin_in = 12'h000;
      alm_peak_in = 16'h0000;
      fails = 0;
      samples_checked = 0;
      foreach (stat_in[a, m])
         stat_in[a][m] = 16'h0000;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      check({13'h0000, stat_code}, 16'h0000, "code at reset");
      // all registers, plus one unmapped word, read zero
      foreach (addrs[i]) begin
         reg_read(addrs[i], rd);
         check(rd, 16'h0000, "reset value");
      end
      foreach (stat_in[a, m])
         stat_in[a][m] <= stat_val(a, m);
      // top bin with its amplitude, then inputs move on
      alm_bin_in <= 12'h7FF;
      alm_peak_in <= 16'hBEEF;
      alm_load <= 1'b1;
      @(posedge mclk);
      alm_load <= 1'b0;
      alm_bin_in <= 12'h123;
      alm_peak_in <= 16'h0000;
      @(posedge mclk);
      check(peak_alarm_value, 16'hBEEF, "peak");
      // writes to read-only words must be dropped
      reg_write(`VSR_ADDR_ALM_Z, 8'h55);
      reg_write(`VSR_ADDR_X, 8'h55);
      reg_read(`VSR_ADDR_ALM_Z, rd);
      check(rd, 16'h07FF, "alarm bin");
      reg_read(7'h71, rd);
      check(rd, 16'h07FF, "alarm bin odd");
      check(peak_alarm_value, 16'hBEEF, "peak held");
      // every selector code, each result axis
      foreach (codes[i]) begin
         reg_write(`VSR_ADDR_SEL, codes[i]);
         check(16'(stat_code), 16'(codes[i][2:0]), "code");
         fixed_exp = codes[i][2:0] >= 3'h4 && codes[i][2:0] <= 3'h6;
         check(16'(stat_fixed_fmt), 16'(fixed_exp), "format");
         reg_read(`VSR_ADDR_SEL, rd);
         check(rd, {8'h00, codes[i]}, "selector");
         for (int a = 0; a < 3; a++) begin
            reg_read(7'(`VSR_ADDR_X + 2 * a), rd);
            exp_word = codes[i][2:0] == 3'h7 ? 16'h0000 :
               stat_val(a, codes[i][2:0]);
            check(rd, exp_word, "result");
         end
      end
      // second reset mid-run: registers clear, results stay live
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      check(16'(stat_code), 16'h0000, "code after reset");
      check(16'(stat_fixed_fmt), 16'h0000, "format after reset");
      check(peak_alarm_value, 16'h0000, "peak after reset");
      reg_read(`VSR_ADDR_SEL, rd);
      check(rd, 16'h0000, "selector after reset");
      reg_read(`VSR_ADDR_ALM_Z, rd);
      check(rd, 16'h0000, "bin after reset");
      reg_read(`VSR_ADDR_X, rd);
      check(rd, stat_val(0, 0), "x live after reset");
      wrap_up();
   end
endmodule
